// ### logic/drc_pkg.sv
// Purpose: Constants for the reset and general configuration bank.
// Assumes: Byte-wide registers at fixed offsets.
// Notes: Shared by the bank and its glitch filter.
`default_nettype none
package drc_pkg;
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h01;
    localparam logic [7:0] ADDR_OUT_CFG = 8'h02;
    localparam logic [7:0] ADDR_LINK_CFG = 8'h03;
    localparam logic [7:0] ADDR_DEV_ADDR = 8'h00;
    localparam logic [7:0] RST_RESET_CTRL = 8'h04;
    localparam logic [7:0] RST_OUT_CFG = 8'h80;
    localparam logic [7:0] RST_LINK_CFG = 8'hf0;
    localparam int BIT_KEEP_REGS = 0;
    localparam int BIT_FULL_RESET = 1;
    localparam int BIT_ADDR_SRC = 0;
    localparam int BIT_GATE_PIX = 1;
    localparam int BIT_AUTO_ACK = 2;
    localparam int BIT_PASS_THRU = 3;
    localparam int BIT_FILTER = 4;
    localparam int BIT_PULL_DIR = 5;
    localparam int BIT_CRC_ON = 6;
    localparam int BIT_UNLOCK_SEL = 4;
    localparam int BIT_OSC_FALLBACK = 5;
    localparam int BIT_OVERRIDE = 6;
    localparam int BIT_OUT_EN = 7;
    localparam int FILT_ONE_LANE = 2;
    localparam int FILT_TWO_LANE = 4;
    // Time to hold the logic in reset after a keep-registers reset.
    localparam int RESET_HOLD_NS = 500000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_FULL_CYC = 1;
endpackage
`default_nettype wire

// ### logic/drc_reset_config.sv
// Purpose: Reset and general configuration registers of a link receiver.
// Assumes: Register port from the I2C slave or the control-channel arbiter.
// Notes: The list below gives the rules that the logic carries.
// Overview of operation
// - Bit 1 resets logic and all registers
// - Full reset reloads strap-loaded register values
// - Bit 0 resets logic, registers kept
// - Override bit selects written output controls
// - Without override, output enable reads one
// - Bit 4 picks unlocked output state
// - Oscillator clock on pixel clock when unlocked
// - Back channel CRC enable, default on
// - Pull direction for undriven inputs
// - Filter short sync and valid pulses
// - Forward matching I2C to remote serializer
// - Auto-acknowledge I2C writes regardless of lock
// - Gate pixels by data-valid when set
// - Address source: strap or programmed
`timescale 1ns/100ps
`default_nettype none
module drc_reset_config
    import drc_pkg::*;
#(
    parameter int HOLD_CYC = RESET_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic [6:0] strapAddr,
    input wire logic linkLocked,
    input wire logic protectedPartner,
    input wire logic dualLane,
    input wire logic oscClk,
    input wire logic recoveredPixClk,
    input wire logic lineSyncIn,
    input wire logic frameSyncIn,
    input wire logic dataValidIn,
    input wire logic [23:0] pixelIn,
    input wire logic addrMatch,
    output logic logicReset,
    output logic outputEnable,
    output logic unlockedStateSel,
    output logic pixClkOut,
    output logic backLinkCrcOn,
    output logic undrivenPullDir,
    output logic lineSyncOut,
    output logic frameSyncOut,
    output logic dataValidOut,
    output logic [23:0] pixelOut,
    output logic forwardI2c,
    output logic autoAck,
    output logic [6:0] deviceAddr
);
    // The hold counter is twenty bits wide.
    if (HOLD_CYC < 1 || HOLD_CYC > 20'hfffff) begin : g_hold_check
        $error("HOLD_CYC outside what the hold counter can serve");
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic strapTaken_q, strapTaken_d;
    logic [6:0] strap_q, strap_d;
    always_comb begin
        strapTaken_d = 1'b1;
        strap_d = strapTaken_q ? strap_q : strapAddr;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            strapTaken_q <= 1'b0;
            strap_q <= 7'h00;
        end else begin
            strapTaken_q <= strapTaken_d;
            strap_q <= strap_d;
        end
    end

    // ------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FULL = 2'b01,
        ST_KEEP = 2'b10
    } drc_rst_state_t;
    drc_rst_state_t st_q, st_d;
    logic [19:0] hold_q, hold_d;
    logic wrReset;
    assign wrReset = regWrite && (regAddr == ADDR_RESET_CTRL);
    always_comb begin
        st_d = st_q;
        hold_d = hold_q;
        unique case (st_q)
            ST_IDLE: begin
                if (wrReset && regWdata[BIT_FULL_RESET]) begin
                    st_d = ST_FULL;
                    hold_d = 20'(RESET_FULL_CYC);
                end else if (wrReset && regWdata[BIT_KEEP_REGS]) begin
                    st_d = ST_KEEP;
                    hold_d = 20'(HOLD_CYC);
                end
            end
            ST_FULL, ST_KEEP: begin
                hold_d = hold_q - 20'h1;
                if (hold_q <= 20'h1) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            hold_q <= 20'h0;
        end else begin
            st_q <= st_d;
            hold_q <= hold_d;
        end
    end
    logic fullClr;
    assign fullClr = (st_q == ST_FULL);
    assign logicReset = (st_q != ST_IDLE);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] rstReg_q, rstReg_d;
    logic [7:0] outCfg_q, outCfg_d;
    logic [7:0] linkCfg_q, linkCfg_d;
    logic [7:0] devAddr_q, devAddr_d;
    always_comb begin
        rstReg_d = rstReg_q;
        outCfg_d = outCfg_q;
        linkCfg_d = linkCfg_q;
        devAddr_d = devAddr_q;
        if (fullClr) begin
            rstReg_d = RST_RESET_CTRL;
            outCfg_d = RST_OUT_CFG;
            linkCfg_d = RST_LINK_CFG;
            devAddr_d = {strap_q, 1'b0};
        end else if (regWrite) begin
            if (regAddr == ADDR_RESET_CTRL) begin
                // Reserved bits keep what was written.
                rstReg_d = {regWdata[7:2], 2'b00};
            end
            if (regAddr == ADDR_OUT_CFG) begin
                outCfg_d = regWdata;
            end
            if (regAddr == ADDR_LINK_CFG) begin
                linkCfg_d = regWdata;
            end
            if (regAddr == ADDR_DEV_ADDR) begin
                devAddr_d = regWdata;
            end
        end
        if (!strapTaken_q) begin
            devAddr_d = {strapAddr, 1'b0};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rstReg_q <= RST_RESET_CTRL;
            outCfg_q <= RST_OUT_CFG;
            linkCfg_q <= RST_LINK_CFG;
            devAddr_q <= 8'h00;
        end else begin
            rstReg_q <= rstReg_d;
            outCfg_q <= outCfg_d;
            linkCfg_q <= linkCfg_d;
            devAddr_q <= devAddr_d;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (regRead) begin
            unique case (regAddr)
                // Self-clearing bits show set until the action ends.
                ADDR_RESET_CTRL: rdata_d = {rstReg_q[7:2],
                    st_q == ST_FULL, st_q == ST_KEEP};
                ADDR_OUT_CFG: rdata_d = outCfg_q;
                ADDR_LINK_CFG: rdata_d = linkCfg_q;
                ADDR_DEV_ADDR: rdata_d = devAddr_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign regRdata = rdata_q;

    // ------------------------------------------------------------
    // Effective controls
    // ------------------------------------------------------------
    logic ovr;
    assign ovr = outCfg_q[BIT_OVERRIDE];
    assign outputEnable = ovr ? outCfg_q[BIT_OUT_EN] : 1'b1;
    assign unlockedStateSel = ovr ? outCfg_q[BIT_UNLOCK_SEL] : 1'b1;
    assign backLinkCrcOn = linkCfg_q[BIT_CRC_ON];
    assign undrivenPullDir = linkCfg_q[BIT_PULL_DIR];
    assign forwardI2c = linkCfg_q[BIT_PASS_THRU] && addrMatch;
    assign autoAck = linkCfg_q[BIT_AUTO_ACK];
    assign deviceAddr = devAddr_q[BIT_ADDR_SRC] ?
        devAddr_q[7:1] : strap_q;

    // ------------------------------------------------------------
    // Lock synchroniser and clock substitution
    // ------------------------------------------------------------
    logic lockS1_q, lockS2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            lockS1_q <= 1'b0;
            lockS2_q <= 1'b0;
        end else begin
            lockS1_q <= linkLocked;
            lockS2_q <= lockS1_q;
        end
    end
    logic useOsc;
    assign useOsc = outCfg_q[BIT_OSC_FALLBACK] && !lockS2_q;
    // Clock mux; a glitch-free cell replaces this in the physical flow.
    assign pixClkOut = useOsc ? oscClk : recoveredPixClk;

    // ------------------------------------------------------------
    // Sync filtering and pixel gating
    // ------------------------------------------------------------
    logic [2:0] syncIn, syncOut;
    assign syncIn = {dataValidIn, frameSyncIn, lineSyncIn};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            drc_sync_filter #(
                .MAX_LEN(FILT_TWO_LANE)
            ) u_filt (
                .clk(clk),
                .rst(rst || logicReset),
                .enable(linkCfg_q[BIT_FILTER]),
                .dualLane(dualLane),
                .din(syncIn[gi]),
                .dout(syncOut[gi])
            );
        end
    endgenerate
    assign lineSyncOut = syncOut[0];
    assign frameSyncOut = syncOut[1];
    assign dataValidOut = syncOut[2];
    logic [23:0] pix_q, pix_d;
    logic gate;
    always_comb begin
        gate = protectedPartner || linkCfg_q[BIT_GATE_PIX];
        pix_d = (gate && !syncOut[2]) ? 24'h000000 : pixelIn;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pix_q <= 24'h000000;
        end else begin
            pix_q <= pix_d;
        end
    end
    assign pixelOut = pix_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_full_reset_defaults: assert property (
        @(posedge clk) disable iff (rst)
        fullClr |=> (outCfg_q == RST_OUT_CFG && linkCfg_q == RST_LINK_CFG))
        else $error("full reset did not restore defaults");
    a_strap_reload: assert property (
        @(posedge clk) disable iff (rst)
        fullClr |=> devAddr_q == {$past(strap_q), 1'b0})
        else $error("strap value not reloaded");
    a_keep_regs: assert property (
        @(posedge clk) disable iff (rst)
        (st_q == ST_KEEP && !regWrite) |=> $stable(outCfg_q))
        else $error("keep-regs reset changed a register");
    a_override_oe: assert property (
        @(posedge clk) disable iff (rst)
        !outCfg_q[BIT_OVERRIDE] |-> (outputEnable && unlockedStateSel))
        else $error("default output controls wrong");
    a_osc_select: assert property (
        @(posedge clk) disable iff (rst)
        (outCfg_q[BIT_OSC_FALLBACK] && !lockS2_q) |-> pixClkOut == oscClk)
        else $error("oscillator not substituted");
    a_crc_default: assert property (
        @(posedge clk) disable iff (rst)
        fullClr |=> backLinkCrcOn)
        else $error("crc enable not restored by full reset");
    a_gate_pixels: assert property (
        @(posedge clk) disable iff (rst)
        (protectedPartner && !syncOut[2]) |=> pixelOut == 24'h000000)
        else $error("pixels not gated");
    a_addr_source: assert property (
        @(posedge clk) disable iff (rst)
        !devAddr_q[0] |-> deviceAddr == strap_q)
        else $error("address source wrong");
    a_self_clear: assert property (
        @(posedge clk) disable iff (rst)
        (st_q == ST_FULL) |=> st_q == ST_IDLE)
        else $error("full reset bit did not clear");
endmodule // drc_reset_config
`default_nettype wire

// ### logic/drc_sync_filter.sv
// Purpose: Rejects short pulses on one sync or data-valid line.
// Assumes: Input already on the local clock.
// Notes: The output follows a new level once it has stood minLen cycles.
`timescale 1ns/100ps
`default_nettype none
module drc_sync_filter
    import drc_pkg::*;
#(
    parameter int MAX_LEN = FILT_TWO_LANE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic dualLane,
    input wire logic din,
    output logic dout
);
    // The four-bit counter cannot serve lengths beyond fifteen.
    if (MAX_LEN < FILT_TWO_LANE || MAX_LEN > 15) begin : g_len_check
        $error("MAX_LEN outside what the counter can serve");
    end
    logic [3:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic [3:0] need;
    always_comb begin
        need = dualLane ? 4'(FILT_TWO_LANE) : 4'(FILT_ONE_LANE);
        cnt_d = 4'h0;
        out_d = out_q;
        if (!enable) begin
            out_d = din;
        end else if (din != out_q) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 >= need) begin
                out_d = din;
                cnt_d = 4'h0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 4'h0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
    assign dout = out_q;
endmodule // drc_sync_filter
`default_nettype wire

// ### testbench/deser_reset_and_general_config_tb.sv
// Purpose: Self-checking bench for the reset and configuration bank.
// Assumes: Shortened keep-registers reset hold of eight cycles.
// Notes: Strap pins are tied to one value.
`timescale 1ns/100ps
`default_nettype none
module deser_reset_and_general_config_tb;
    import drc_pkg::*;
    localparam int HOLD = 8;
    localparam logic [6:0] STRAP = 7'h3c;
    localparam logic [7:0] OC_W [5] = '{8'h40, 8'h50, 8'hc0, 8'h0f, 8'hd0};
    localparam logic [1:0] OC_E [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic clk, rst, regWrite, regRead, linkLocked, protectedPartner;
    logic dualLane, oscClk, recClk, syncIn, addrMatch, logicReset;
    logic outputEnable, unlockedStateSel, pixClkOut, backLinkCrcOn;
    logic undrivenPullDir, lineSyncOut, frameSyncOut, dataValidOut;
    logic forwardI2c, autoAck;
    logic [7:0] regAddr, regWdata, regRdata, rv;
    logic [6:0] deviceAddr;
    logic [23:0] pixelIn, pixelOut;
    int miscompares, checksDone, cnt;
    drc_reset_config #(.HOLD_CYC(HOLD)) dut_u (
        .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .strapAddr(STRAP), .linkLocked(linkLocked),
        .protectedPartner(protectedPartner), .dualLane(dualLane),
        .oscClk(oscClk), .recoveredPixClk(recClk), .lineSyncIn(syncIn),
        .frameSyncIn(syncIn), .dataValidIn(syncIn), .pixelIn(pixelIn),
        .addrMatch(addrMatch), .logicReset(logicReset),
        .outputEnable(outputEnable), .unlockedStateSel(unlockedStateSel),
        .pixClkOut(pixClkOut), .backLinkCrcOn(backLinkCrcOn),
        .undrivenPullDir(undrivenPullDir), .lineSyncOut(lineSyncOut),
        .frameSyncOut(frameSyncOut), .dataValidOut(dataValidOut),
        .pixelOut(pixelOut), .forwardI2c(forwardI2c), .autoAck(autoAck),
        .deviceAddr(deviceAddr));
    drc_host_model host_u (
        .clk(clk), .regRdata(regRdata), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [23:0] seen,
            input logic [23:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, rv);
        check("register", {16'h0000, rv}, {16'h0000, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(input logic dual, input int len, input logic exp);
        logic [2:0] seen;
        seen = 3'h0;
        dualLane = dual;
        cyc(6);
        syncIn = 1'b1;
        for (int k = 0; k < len + 8; k++) begin
            if (k == len) begin
                syncIn = 1'b0;
            end
            @(negedge clk);
            seen = seen | {lineSyncOut, frameSyncOut, dataValidOut};
        end
        check("filtered sync", {21'h0, seen}, {21'h0, {3{exp}}});
    endtask
    task automatic finish_test();
        if (miscompares == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {linkLocked, protectedPartner, dualLane, addrMatch} = 4'h8;
        {oscClk, recClk, syncIn} = 3'h4;
        pixelIn = 24'habcdef;
        miscompares = 0;
        checksDone = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rdchk(ADDR_RESET_CTRL, RST_RESET_CTRL);
        rdchk(ADDR_OUT_CFG, RST_OUT_CFG);
        rdchk(ADDR_LINK_CFG, RST_LINK_CFG);
        rdchk(ADDR_DEV_ADDR, {STRAP, 1'b0});
        rdchk(8'h6c, 8'h00);
        check("outs", 24'({outputEnable, unlockedStateSel, backLinkCrcOn,
            undrivenPullDir, autoAck, forwardI2c}), 24'h3c);
        check("device address", 24'(deviceAddr), 24'(STRAP));
        for (int i = 0; i < 5; i++) begin
            host_u.wr(ADDR_OUT_CFG, OC_W[i]);
            rdchk(ADDR_OUT_CFG, OC_W[i]);
            check("out ctl", 24'({outputEnable, unlockedStateSel}),
                24'(OC_E[i]));
        end
        host_u.keep_reset();
        check("reset active", 24'(logicReset), 24'h1);
        cnt = 0;
        while (logicReset === 1'b1 && cnt < 40) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 40) begin
            miscompares++;
            finish_test();
        end
        check("reset length", 24'(cnt), 24'(HOLD));
        rdchk(ADDR_RESET_CTRL, 8'h04);
        rdchk(ADDR_OUT_CFG, 8'hd0);
        host_u.wr(ADDR_LINK_CFG, 8'h0e);
        check("link outs", 24'({backLinkCrcOn, undrivenPullDir, autoAck}),
            24'h1);
        addrMatch = 1'b1;
        cyc(1);
        check("forward", 24'(forwardI2c), 24'h1);
        host_u.wr(ADDR_LINK_CFG, 8'h06);
        check("forward off", 24'(forwardI2c), 24'h0);
        host_u.wr(ADDR_DEV_ADDR, {7'h2a, 1'b1});
        check("programmed address", 24'(deviceAddr), 24'h2a);
        host_u.wr(ADDR_RESET_CTRL, 8'hfa);
        check("full reset active", 24'(logicReset), 24'h1);
        cyc(1);
        rdchk(ADDR_RESET_CTRL, 8'h04);
        rdchk(ADDR_LINK_CFG, 8'hf0);
        rdchk(ADDR_OUT_CFG, 8'h80);
        rdchk(ADDR_DEV_ADDR, {STRAP, 1'b0});
        check("strap address", 24'(deviceAddr), 24'(STRAP));
        host_u.wr(ADDR_RESET_CTRL, 8'hf8);
        check("no reset", 24'(logicReset), 24'h0);
        rdchk(ADDR_RESET_CTRL, 8'hf8);
        host_u.wr(ADDR_LINK_CFG, 8'h02);
        cyc(3);
        check("gated pixels", pixelOut, 24'h0);
        syncIn = 1'b1;
        cyc(3);
        check("valid pixels", pixelOut, 24'habcdef);
        syncIn = 1'b0;
        host_u.wr(ADDR_LINK_CFG, 8'h00);
        protectedPartner = 1'b1;
        cyc(3);
        check("protected gating", pixelOut, 24'h0);
        protectedPartner = 1'b0;
        cyc(3);
        check("ungated pixels", pixelOut, 24'habcdef);
        host_u.wr(ADDR_LINK_CFG, 8'h10);
        pulse(1'b0, 1, 1'b0);
        pulse(1'b0, 2, 1'b1);
        pulse(1'b1, 3, 1'b0);
        pulse(1'b1, 4, 1'b1);
        linkLocked = 1'b0;
        host_u.wr(ADDR_OUT_CFG, 8'ha0);
        cyc(4);
        check("osc clock", 24'(pixClkOut), 24'h1);
        {oscClk, recClk} = 2'h1;
        linkLocked = 1'b1;
        #1;
        check("osc clock low", 24'(pixClkOut), 24'h0);
        cyc(4);
        check("recovered clock", 24'(pixClkOut), 24'h1);
        finish_test();
    end
endmodule // deser_reset_and_general_config_tb
`default_nettype wire

// ### testbench/drc_host_model.sv
// Purpose: Register master model on the byte register port.
// Assumes: Requests change at the falling edge and are taken at the rising.
// Notes: Carries the software duties of the keep-registers reset.
`timescale 1ns/100ps
`default_nettype none
module drc_host_model (
    input wire logic clk,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regWdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        d = regRdata;
    endtask
    // The camera port index is preset before the reset is requested.
    task automatic keep_reset();
        wr(8'h6c, 8'hff);
        wr(8'h01, 8'h05);
    endtask
endmodule // drc_host_model
`default_nettype wire
